// ---- hdl/csma_regs.svh ----
// register offsets, field positions, reset values and timing counts
// assumes 32-bit AXI4-Lite words, byte addresses in the low eight bits
`ifndef CSMA_REGS_SVH
`define CSMA_REGS_SVH

// ==========================================================
// offsets
`define CSMA_OFF_CTRL 8'h00
`define CSMA_OFF_BIT_TIME 8'h04
`define CSMA_OFF_SLOT_TIME 8'h08
`define CSMA_OFF_SLOT_CFG 8'h0C
`define CSMA_OFF_GAP 8'h10
`define CSMA_OFF_FRAME_CFG 8'h14
`define CSMA_OFF_STATUS 8'h18
`define CSMA_OFF_EVENTS 8'h1C

// ==========================================================
// fields
`define CSMA_CTRL_START 0
`define CSMA_CTRL_PRIO 1
`define CSMA_CTRL_MODE_LO 2
`define CSMA_CTRL_PRE_COL 4
`define CSMA_CTRL_POST_COL 5
`define CSMA_MODE_DIFF 2'h0
`define CSMA_MODE_SINGLE 2'h1
`define CSMA_MODE_SPECIAL 2'h2
`define CSMA_EV_DONE 0
`define CSMA_EV_CANCEL 1
`define CSMA_EV_COL_END 2
`define CSMA_EV_COL_POST 3

// ==========================================================
// reset values
`define CSMA_RST_BIT_TIME 16'h0064
`define CSMA_RST_SLOT_TIME 16'h00C8
`define CSMA_RST_SLOT_CFG 32'h0004_0010
`define CSMA_RST_GAP 16'h0100
`define CSMA_RST_FRAME_CFG 32'h0000_0420

// ==========================================================
// timing counts
`define CSMA_PRE_CYC_STD 16'h010E
`define CSMA_PRE_CYC_SPECIAL 16'h013D
`define CSMA_ACT_HOLD_BITS 18'h00003
`define CSMA_CV_BITS 8'h02
`define CSMA_MIN_BIT_CYC 16'h0002
`define CSMA_SYNC_MIN 3'h4

`endif

// ---- hdl/csma_pkg.sv ----
// types shared by the access timing block
// assumes the register header supplies all numbers
package csma_pkg;

  // ==========================================================
  // bus carriers
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_type;

  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_IDLE_WAIT,
    ST_PRE,
    ST_COUNT,
    ST_PREAMBLE,
    ST_DATA,
    ST_VIOL,
    ST_GAP
  } state_type;

endpackage

// ---- hdl/chan_monitor.sv ----
// line activity latch and bit sync qualification
// assumes a raw line pin from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
`include "csma_regs.svh"

module chan_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic rxd_i,
  input wire logic [15:0] bit_cyc_i,
  input wire logic [2:0] thresh_i,
  output var logic active_o,
  output var logic qualified_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic edge_w;
  logic [17:0] hold_q;
  logic [15:0] ph_q;
  logic [2:0] run_q;
  logic [2:0] thr_w;
  logic in_window_w;

  // ==========================================================
  // pin synchroniser
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else if (ce_i)
    begin
      s1_q <= rxd_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign edge_w = s2_q ^ s3_q;

  // ==========================================================
  // activity held three bit times
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      hold_q <= 18'h00000;
    else if (ce_i)
    begin
      if (edge_w)
        hold_q <= 18'(bit_cyc_i * `CSMA_ACT_HOLD_BITS);
      else if (hold_q != 18'h00000)
        hold_q <= hold_q - 18'h00001;
    end
  end

  assign active_o = (hold_q != 18'h00000) || edge_w;

  // ==========================================================
  // bit phase resync and sync count
  assign thr_w = (thresh_i < `CSMA_SYNC_MIN) ? `CSMA_SYNC_MIN : thresh_i;
  assign in_window_w = (ph_q >= (bit_cyc_i >> 1)) && (ph_q <= (bit_cyc_i + (bit_cyc_i >> 1)));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ph_q <= 16'h0000;
      run_q <= 3'h0;
      qualified_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (edge_w)
      begin
        ph_q <= 16'h0000;
        if (in_window_w && run_q != 3'h7)
          run_q <= run_q + 3'h1;
        else if (!in_window_w)
          run_q <= 3'h1;
        if (in_window_w && (run_q + 3'h1) >= thr_w)
          qualified_o <= 1'b1;
      end
      else if (ph_q != 16'hFFFF)
        ph_q <= ph_q + 16'h0001;
      if (!active_o)
      begin
        run_q <= 3'h0;
        qualified_o <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- hdl/csma_mac_slot_collision.sv ----
// access slot sequencer, line transmitter and collision handling
// assumes an AXI4-Lite master, a line transceiver and a bit source
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "csma_regs.svh"

// How it works
// - single-ended gap ends at transmit enable rise
// - one idle slot, else wait for idle
// - pre-packet 270 cycles, special mode 317
// - count down N slots before sending
// - slot never shorter than one bit
// - slot wide enough to see earlier sender
// - transmit starts within one bit time
// - any transition latched active three bits
// - preamble collision cancels, retry at once
// - end check always, preamble/post selectable
// - enabled preamble collision terminates, else complete
// - collisions ignored first quarter of preamble
// - special mode collision terminates at once
// - receiver resyncs bit phase on transitions
// - post-packet handling starts same cycle
// - qualify after four to seven sync bits
// - differential gap ends at first transition
module csma_mac_slot_collision (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic CLK_EN_I,
  input wire csma_pkg::axil_req_type AXI_REQ_I,
  output var csma_pkg::axil_rsp_type AXI_RSP_O,
  input wire logic RXD_I,
  input wire logic COL_I,
  input wire logic PKT_BIT_I,
  input wire logic PKT_LAST_I,
  output var logic PKT_TAKE_O,
  output var logic TXD_O,
  output var logic TX_EN_O,
  output var logic ACTIVITY_O,
  output var logic QUALIFIED_O
);

  csma_pkg::state_type st_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_do;
  logic prio_q;
  logic [1:0] mode_q;
  logic pre_col_q;
  logic post_col_q;
  logic pend_q;
  logic [15:0] bit_time_q;
  logic [15:0] slot_time_q;
  logic [31:0] slot_cfg_q;
  logic [15:0] gap_q;
  logic [31:0] frame_cfg_q;
  logic [3:0] ev_q;
  logic [3:0] ev_set_q;
  logic col_s1_q;
  logic col_s2_q;
  logic [15:0] lfsr_q;
  logic [15:0] cnt_q;
  logic [15:0] ph_q;
  logic [7:0] slots_q;
  logic [7:0] bits_q;
  logic cur_bit_q;
  logic last_q;
  logic active_w;
  logic special_w;
  logic [15:0] eff_bit_w;
  logic [15:0] slot_w;
  logic [15:0] pre_len_w;
  logic bit_end_w;
  logic half_w;
  logic [7:0] rand_n_w;
  logic [7:0] pick_w;
  logic col_mask_off_w;

  // ==========================================================
  // channel monitor
  chan_monitor u_mon (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .ce_i(CLK_EN_I),
    .rxd_i(RXD_I),
    .bit_cyc_i(eff_bit_w),
    .thresh_i(frame_cfg_q[10:8]),
    .active_o(active_w),
    .qualified_o(QUALIFIED_O)
  );

  assign ACTIVITY_O = active_w;

  // ==========================================================
  // AXI4-Lite write path
  assign wr_do = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
    end
    else if (CLK_EN_I)
    begin
      if (AXI_REQ_I.awvalid && !aw_have_q && !bvalid_q)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= AXI_REQ_I.awaddr[7:0];
      end
      if (AXI_REQ_I.wvalid && !w_have_q && !bvalid_q)
      begin
        w_have_q <= 1'b1;
        wdata_q <= AXI_REQ_I.wdata;
        wstrb_q <= AXI_REQ_I.wstrb;
      end
      if (wr_do)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr_q[7:5] == 3'h0 && awaddr_q[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end
      else if (bvalid_q && AXI_REQ_I.bready)
        bvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
    end
    else if (CLK_EN_I)
    begin
      if (AXI_REQ_I.arvalid && !rvalid_q)
      begin
        rvalid_q <= 1'b1;
        rresp_q <= 2'h0;
        unique case (AXI_REQ_I.araddr[7:0])
          `CSMA_OFF_CTRL: rdata_q <= {26'h0, post_col_q, pre_col_q, mode_q, prio_q, pend_q};
          `CSMA_OFF_BIT_TIME: rdata_q <= {16'h0000, bit_time_q};
          `CSMA_OFF_SLOT_TIME: rdata_q <= {16'h0000, slot_time_q};
          `CSMA_OFF_SLOT_CFG: rdata_q <= slot_cfg_q;
          `CSMA_OFF_GAP: rdata_q <= {16'h0000, gap_q};
          `CSMA_OFF_FRAME_CFG: rdata_q <= frame_cfg_q;
          `CSMA_OFF_STATUS: rdata_q <= {16'h0000, slots_q, 4'(st_q), TX_EN_O, QUALIFIED_O,
                                        active_w, pend_q};
          `CSMA_OFF_EVENTS: rdata_q <= {28'h0000000, ev_q};
          default:
          begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h2;
          end
        endcase
      end
      else if (rvalid_q && AXI_REQ_I.rready)
        rvalid_q <= 1'b0;
    end
  end

  assign AXI_RSP_O = '{awready: !aw_have_q && !bvalid_q, wready: !w_have_q && !bvalid_q,
                       bvalid: bvalid_q, bresp: bresp_q, arready: !rvalid_q,
                       rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};

  // ==========================================================
  // configuration registers
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    return res;
  endfunction

  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      prio_q <= 1'b0;
      mode_q <= `CSMA_MODE_DIFF;
      pre_col_q <= 1'b0;
      post_col_q <= 1'b0;
      bit_time_q <= `CSMA_RST_BIT_TIME;
      slot_time_q <= `CSMA_RST_SLOT_TIME;
      slot_cfg_q <= `CSMA_RST_SLOT_CFG;
      gap_q <= `CSMA_RST_GAP;
      frame_cfg_q <= `CSMA_RST_FRAME_CFG;
    end
    else if (CLK_EN_I && wr_do)
    begin
      unique case (awaddr_q)
        `CSMA_OFF_CTRL:
          if (wstrb_q[0])
          begin
            prio_q <= wdata_q[`CSMA_CTRL_PRIO];
            mode_q <= wdata_q[`CSMA_CTRL_MODE_LO +: 2];
            pre_col_q <= wdata_q[`CSMA_CTRL_PRE_COL];
            post_col_q <= wdata_q[`CSMA_CTRL_POST_COL];
          end
        `CSMA_OFF_BIT_TIME: bit_time_q <= 16'(merge({16'h0000, bit_time_q}, wdata_q, wstrb_q));
        `CSMA_OFF_SLOT_TIME: slot_time_q <= 16'(merge({16'h0000, slot_time_q}, wdata_q, wstrb_q));
        `CSMA_OFF_SLOT_CFG: slot_cfg_q <= merge(slot_cfg_q, wdata_q, wstrb_q);
        `CSMA_OFF_GAP: gap_q <= 16'(merge({16'h0000, gap_q}, wdata_q, wstrb_q));
        `CSMA_OFF_FRAME_CFG: frame_cfg_q <= merge(frame_cfg_q, wdata_q, wstrb_q) & 32'h0000_07FF;
        default:
        begin
        end
      endcase
    end
  end

  // ==========================================================
  // pending request and sticky events, set wins
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      pend_q <= 1'b0;
      ev_q <= 4'h0;
    end
    else if (CLK_EN_I)
    begin
      if (wr_do && awaddr_q == `CSMA_OFF_CTRL && wstrb_q[0] && wdata_q[`CSMA_CTRL_START])
        pend_q <= 1'b1;
      else if (ev_set_q[`CSMA_EV_DONE])
        pend_q <= 1'b0;
      if (wr_do && awaddr_q == `CSMA_OFF_EVENTS && wstrb_q[0])
        ev_q <= (ev_q & ~wdata_q[3:0]) | ev_set_q;
      else
        ev_q <= ev_q | ev_set_q;
    end
  end

  // ==========================================================
  // collision pin synchroniser and slot randomiser
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      col_s1_q <= 1'b0;
      col_s2_q <= 1'b0;
      lfsr_q <= 16'hACE1;
    end
    else if (CLK_EN_I)
    begin
      col_s1_q <= COL_I;
      col_s2_q <= col_s1_q;
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  // ==========================================================
  // derived timing
  assign special_w = (mode_q == `CSMA_MODE_SPECIAL);
  assign eff_bit_w = (bit_time_q < `CSMA_MIN_BIT_CYC) ? `CSMA_MIN_BIT_CYC : bit_time_q;
  assign slot_w = (slot_time_q < eff_bit_w) ? eff_bit_w : slot_time_q;
  assign pre_len_w = special_w ? `CSMA_PRE_CYC_SPECIAL : `CSMA_PRE_CYC_STD;
  assign bit_end_w = (ph_q == eff_bit_w - 16'h0001);
  assign half_w = (ph_q == (eff_bit_w >> 1) - 16'h0001);
  assign rand_n_w = slot_cfg_q[7:0];
  assign pick_w = prio_q ? slot_cfg_q[15:8] : 8'(slot_cfg_q[23:16] +
                  ((rand_n_w == 8'h00) ? 8'h00 : 8'(lfsr_q[7:0] % rand_n_w)));
  assign col_mask_off_w = (bits_q >= (frame_cfg_q[7:0] >> 2));
  assign PKT_TAKE_O = (st_q == csma_pkg::ST_DATA) && bit_end_w && CLK_EN_I;

  // ==========================================================
  // access sequencer and line transmitter
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      st_q <= csma_pkg::ST_IDLE;
      cnt_q <= 16'h0000;
      ph_q <= 16'h0000;
      slots_q <= 8'h00;
      bits_q <= 8'h00;
      cur_bit_q <= 1'b0;
      last_q <= 1'b0;
      TXD_O <= 1'b0;
      TX_EN_O <= 1'b0;
      ev_set_q <= 4'h0;
    end
    else if (CLK_EN_I)
    begin
      ev_set_q <= 4'h0;
      ph_q <= bit_end_w ? 16'h0000 : ph_q + 16'h0001;
      unique case (st_q)
        csma_pkg::ST_IDLE:
        begin
          cnt_q <= 16'h0000;
          if (pend_q)
            st_q <= csma_pkg::ST_IDLE_WAIT;
        end
        csma_pkg::ST_IDLE_WAIT:
        begin
          if (active_w)
            cnt_q <= 16'h0000;
          else if (cnt_q == slot_w - 16'h0001)
          begin
            cnt_q <= 16'h0000;
            slots_q <= pick_w;
            st_q <= csma_pkg::ST_PRE;
          end
          else
            cnt_q <= cnt_q + 16'h0001;
        end
        csma_pkg::ST_PRE:
        begin
          if (cnt_q == pre_len_w - 16'h0001)
          begin
            cnt_q <= 16'h0000;
            st_q <= csma_pkg::ST_COUNT;
          end
          else
            cnt_q <= cnt_q + 16'h0001;
        end
        csma_pkg::ST_COUNT:
        begin
          if (active_w)
          begin
            cnt_q <= 16'h0000;
            st_q <= csma_pkg::ST_IDLE_WAIT;
          end
          else if (slots_q == 8'h00)
          begin
            // first transition and enable rise in one cycle, line held unchanged in special mode
            TX_EN_O <= 1'b1;
            TXD_O <= special_w ? TXD_O : ~TXD_O;
            ph_q <= special_w ? 16'h0000 : 16'h0001;
            bits_q <= 8'h00;
            last_q <= 1'b0;
            st_q <= special_w ? csma_pkg::ST_DATA : csma_pkg::ST_PREAMBLE;
          end
          else if (cnt_q == slot_w - 16'h0001)
          begin
            cnt_q <= 16'h0000;
            slots_q <= slots_q - 8'h01;
          end
          else
            cnt_q <= cnt_q + 16'h0001;
        end
        csma_pkg::ST_PREAMBLE:
        begin
          if (col_s2_q && col_mask_off_w && pre_col_q)
          begin
            TX_EN_O <= 1'b0;
            ev_set_q[`CSMA_EV_CANCEL] <= 1'b1;
            cnt_q <= 16'h0000;
            st_q <= csma_pkg::ST_IDLE_WAIT;
          end
          else
          begin
            if (ph_q == 16'h0000)
              TXD_O <= ~TXD_O;
            if (bit_end_w)
            begin
              bits_q <= bits_q + 8'h01;
              if (bits_q >= frame_cfg_q[7:0] - 8'h01)
                st_q <= csma_pkg::ST_DATA;
            end
          end
        end
        csma_pkg::ST_DATA:
        begin
          if (col_s2_q && special_w)
          begin
            TX_EN_O <= 1'b0;
            ev_set_q[`CSMA_EV_CANCEL] <= 1'b1;
            cnt_q <= 16'h0000;
            st_q <= csma_pkg::ST_IDLE_WAIT;
          end
          else
          begin
            if (col_s2_q && last_q)
              ev_set_q[`CSMA_EV_COL_END] <= 1'b1;
            if (ph_q == 16'h0000)
            begin
              TXD_O <= special_w ? PKT_BIT_I : ~TXD_O;
              cur_bit_q <= PKT_BIT_I;
              last_q <= PKT_LAST_I;
            end
            else if (half_w && !special_w && !cur_bit_q)
              TXD_O <= ~TXD_O;
            if (bit_end_w && last_q)
            begin
              bits_q <= 8'h00;
              cnt_q <= 16'h0000;
              if (special_w)
              begin
                TX_EN_O <= 1'b0;
                ev_set_q[`CSMA_EV_DONE] <= 1'b1;
                st_q <= csma_pkg::ST_GAP;
              end
              else
                st_q <= csma_pkg::ST_VIOL;
            end
          end
        end
        csma_pkg::ST_VIOL:
        begin
          if (col_s2_q)
            ev_set_q[`CSMA_EV_COL_END] <= 1'b1;
          if (bit_end_w)
            bits_q <= bits_q + 8'h01;
          if (ph_q == 16'h0000 && bits_q == `CSMA_CV_BITS)
          begin
            TX_EN_O <= 1'b0;
            ev_set_q[`CSMA_EV_DONE] <= 1'b1;
            cnt_q <= 16'h0000;
            st_q <= csma_pkg::ST_GAP;
          end
        end
        csma_pkg::ST_GAP:
        begin
          if (col_s2_q && post_col_q && !special_w)
            ev_set_q[`CSMA_EV_COL_POST] <= 1'b1;
          if (cnt_q >= gap_q)
          begin
            cnt_q <= 16'h0000;
            st_q <= pend_q ? csma_pkg::ST_IDLE_WAIT : csma_pkg::ST_IDLE;
          end
          else
            cnt_q <= cnt_q + 16'h0001;
        end
        default:
          st_q <= csma_pkg::ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- tb/csma_mac_slot_collision_properties.sv ----
// checker for the access timing block ports
// assumes it is bound onto the top design module
`timescale 1ns/1ns
`default_nettype none
module csma_props (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic CLK_EN_I,
  input wire csma_pkg::axil_req_type AXI_REQ_I,
  input wire csma_pkg::axil_rsp_type AXI_RSP_O,
  input wire logic RXD_I,
  input wire logic COL_I,
  input wire logic PKT_BIT_I,
  input wire logic PKT_LAST_I,
  input wire logic PKT_TAKE_O,
  input wire logic TXD_O,
  input wire logic TX_EN_O,
  input wire logic ACTIVITY_O,
  input wire logic QUALIFIED_O
);
  logic [15:0] quiet_q;
  logic [15:0] low_q;
  default clocking dc @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // ==========================================================
  // line quiet and transmitter idle counters
  always_ff @(posedge REF_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      quiet_q <= 16'h0000;
      low_q <= 16'h0000;
    end
    else
    begin
      quiet_q <= $changed(RXD_I) ? 16'h0000 : quiet_q + {15'h0000, quiet_q != 16'hFFFF};
      low_q <= TX_EN_O ? 16'h0000 : low_q + {15'h0000, low_q != 16'hFFFF};
    end
  end
  // ==========================================================
  // properties
  sequence s_wr_take;
    AXI_REQ_I.awvalid && AXI_RSP_O.awready && AXI_REQ_I.wvalid && AXI_RSP_O.wready;
  endsequence
  sequence s_wr_err;
    ##[1:2] AXI_RSP_O.bvalid && AXI_RSP_O.bresp == 2'h2;
  endsequence
  property p_wr_answer;
    s_wr_take |-> ##[1:2] AXI_RSP_O.bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  property p_wr_refuse;
    s_wr_take ##0 AXI_REQ_I.awaddr > 32'h0000_001C |-> s_wr_err;
  endproperty
  a_wr_refuse: assert property (p_wr_refuse) else $error("bad write accepted");
  property p_rd_refuse;
    AXI_REQ_I.arvalid && AXI_RSP_O.arready && AXI_REQ_I.araddr > 32'h0000_001C |=>
      AXI_RSP_O.rvalid && AXI_RSP_O.rresp == 2'h2 && AXI_RSP_O.rdata == 32'h0000_0000;
  endproperty
  a_rd_refuse: assert property (p_rd_refuse) else $error("bad read accepted");
  property p_tx_start;
    $rose(TX_EN_O) |-> TXD_O != $past(TXD_O) && !ACTIVITY_O;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("bad transmit start");
  property p_act_rise;
    $changed(RXD_I) |-> ##[1:4] ACTIVITY_O;
  endproperty
  a_act_rise: assert property (p_act_rise) else $error("activity missed");
  property p_act_hold;
    $fell(ACTIVITY_O) |-> quiet_q >= 16'h0006;
  endproperty
  a_act_hold: assert property (p_act_hold) else $error("activity dropped early");
  property p_qual_drop;
    $fell(ACTIVITY_O) |-> ##[0:1] !QUALIFIED_O;
  endproperty
  a_qual_drop: assert property (p_qual_drop) else $error("qualified stuck");
  property p_take;
    PKT_TAKE_O |-> TX_EN_O ##1 !PKT_TAKE_O;
  endproperty
  a_take: assert property (p_take) else $error("bad bit take");
  property p_pre_wait;
    $rose(TX_EN_O) |-> low_q >= 16'h010E;
  endproperty
  a_pre_wait: assert property (p_pre_wait) else $error("pre-packet too short");
endmodule
bind csma_mac_slot_collision csma_props u_props (
  .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .CLK_EN_I(CLK_EN_I), .AXI_REQ_I(AXI_REQ_I),
  .AXI_RSP_O(AXI_RSP_O), .RXD_I(RXD_I), .COL_I(COL_I), .PKT_BIT_I(PKT_BIT_I),
  .PKT_LAST_I(PKT_LAST_I), .PKT_TAKE_O(PKT_TAKE_O), .TXD_O(TXD_O), .TX_EN_O(TX_EN_O),
  .ACTIVITY_O(ACTIVITY_O), .QUALIFIED_O(QUALIFIED_O)
);
`default_nettype wire

// ---- tb/xcvr_model.sv ----
// line transceiver model: loopback, foreign traffic, collision reports
// assumes the bench commands traffic and collisions
`timescale 1ns/1ns
`default_nettype none
module xcvr_model (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic tx_en_i,
  input wire logic busy_i,
  input wire logic col_i,
  output var logic rxd_o,
  output var logic col_o
);
  logic [1:0] div_q = 2'h0;
  logic foreign_q = 1'b0;
  // ==========================================================
  // foreign sender, one transition per four cycles
  always_ff @(posedge clk_i)
  begin
    div_q <= div_q + 2'h1;
    if (busy_i && div_q == 2'h3)
      foreign_q <= !foreign_q;
  end
  // own line seen at once, idle at termination bias
  assign rxd_o = tx_en_i ? txd_i : (busy_i & foreign_q);
  assign col_o = col_i;
endmodule
`default_nettype wire

// ---- tb/csma_mac_slot_collision_tb_top.sv ----
// self-checking bench for the access timing block
// assumes the transceiver model and the bound checker
`timescale 1ns/1ns
`default_nettype none
`include "csma_regs.svh"
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("mismatch at %0t: got %0h want %0h", $time, got, exp); \
    end \
  end
module csma_mac_slot_collision_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  csma_pkg::axil_req_type req = '0;
  csma_pkg::axil_rsp_type rsp;
  logic rxd, col, take, txd, tx_en, act, qual;
  logic pkt_bit = 1'b0;
  logic pkt_last = 1'b0;
  logic busy = 1'b0;
  logic col_cmd = 1'b0;
  int fails = 0;
  int check_count = 0;
  always #4 clk = !clk;
  csma_mac_slot_collision uut (.REF_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(1'b1),
    .AXI_REQ_I(req), .AXI_RSP_O(rsp), .RXD_I(rxd), .COL_I(col), .PKT_BIT_I(pkt_bit),
    .PKT_LAST_I(pkt_last), .PKT_TAKE_O(take), .TXD_O(txd), .TX_EN_O(tx_en),
    .ACTIVITY_O(act), .QUALIFIED_O(qual));
  xcvr_model xcvr (.clk_i(clk), .txd_i(txd), .tx_en_i(tx_en), .busy_i(busy),
    .col_i(col_cmd), .rxd_o(rxd), .col_o(col));
  // ==========================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    req.awaddr <= {24'h000000, a};
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (rsp.awready === 1'b1)
        req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1)
        req.wvalid <= 1'b0;
    end
    while (rsp.bvalid !== 1'b1 && n < 100);
    `CHK({rsp.bvalid, rsp.bresp}, {1'b1, er})
    req.bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    req.araddr <= {24'h000000, a};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (rsp.arready === 1'b1)
        req.arvalid <= 1'b0;
    end
    while (rsp.rvalid !== 1'b1 && n < 100);
    `CHK(rsp.rdata, ed)
    `CHK({rsp.rvalid, rsp.rresp}, {1'b1, er})
    req.rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ev(input logic [3:0] e);
    rd(`CSMA_OFF_EVENTS, {28'h0000000, e}, 2'h0);
    wr(`CSMA_OFF_EVENTS, 32'h0000_000F, 2'h0);
  endtask
  // ==========================================================
  // packet source and observer
  task automatic step(input int ca, input int k, inout int tk);
    @(posedge clk);
    col_cmd <= (k >= ca && k < ca + 3);
    if (take === 1'b1)
    begin
      tk++;
      pkt_last <= (tk >= 2);
      pkt_bit <= tk[0];
    end
  endtask
  task automatic obs(input int ca, output int wt, output int ln, output logic [1:0] aq);
    int tk;
    int k;
    tk = 0;
    wt = 0;
    k = -100;
    aq = 2'h0;
    while (tx_en !== 1'b1 && wt < 3000)
    begin
      step(ca, k, tk);
      wt++;
    end
    k = 0;
    while (tx_en === 1'b1 && k < 500)
    begin
      k++;
      if (k == 40)
        aq = {act, qual};
      step(ca, k, tk);
    end
    ln = k;
    repeat (20)
    begin
      k++;
      step(ca, k, tk);
    end
    pkt_last <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [31:0] rv [6] = '{32'h0000_0064, 32'h0000_00C8, 32'h0004_0010,
      32'h0000_0100, 32'h0000_0420, 32'h0000_0000};
    for (int i = 0; i < 6; i++)
      rd(8'(4 * i + 4), rv[i], 2'h0);
    rd(8'h20, 32'h0000_0000, 2'h2);
    wr(8'h24, 32'h0000_0001, 2'h2);
    wr(`CSMA_OFF_STATUS, 32'h0000_FFFF, 2'h0);
    rd(`CSMA_OFF_STATUS, 32'h0000_0000, 2'h0);
  endtask
  task automatic t_slots;
    int t0, t3, tn, ln;
    logic [1:0] aq;
    wr(`CSMA_OFF_SLOT_CFG, 32'h0002_0001, 2'h0);
    wr(`CSMA_OFF_CTRL, 32'h0000_0003, 2'h0);
    obs(1000, t0, ln, aq);
    `CHK(t0 >= 278 && t0 <= 290, 1'b1)
    `CHK(aq, 2'h3)
    `CHK(ln, 52)
    ev(4'h1);
    wr(`CSMA_OFF_SLOT_CFG, 32'h0002_0301, 2'h0);
    wr(`CSMA_OFF_CTRL, 32'h0000_0007, 2'h0);
    obs(1000, t3, ln, aq);
    `CHK(t3 - t0, 24)
    ev(4'h1);
    wr(`CSMA_OFF_CTRL, 32'h0000_0001, 2'h0);
    obs(1000, tn, ln, aq);
    `CHK(tn - t0, 16)
    ev(4'h1);
  endtask
  task automatic t_busy;
    int n, tw, ln;
    logic [1:0] aq;
    n = 0;
    busy <= 1'b1;
    wr(`CSMA_OFF_CTRL, 32'h0000_0001, 2'h0);
    repeat (400)
    begin
      @(posedge clk);
      n += (tx_en !== 1'b0);
    end
    `CHK(n, 0)
    busy <= 1'b0;
    obs(1000, tw, ln, aq);
    `CHK(tw >= 294, 1'b1)
    ev(4'h1);
  endtask
  task automatic t_collisions;
    logic [5:0] c [6] = '{6'h11, 6'h11, 6'h01, 6'h01, 6'h21, 6'h01};
    int ca [6] = '{1, 20, 20, 46, 57, 57};
    logic [3:0] e [6] = '{4'h1, 4'h1, 4'h1, 4'h5, 4'h9, 4'h1};
    int tw, ln;
    logic [1:0] aq;
    for (int i = 0; i < 6; i++)
    begin
      wr(`CSMA_OFF_CTRL, {26'h0000000, c[i]}, 2'h0);
      obs(ca[i], tw, ln, aq);
      if (i == 1)
      begin
        `CHK(ln < 32 && ln > 8, 1'b1)
        ev(4'h2);
        obs(1000, tw, ln, aq);
      end
      `CHK(ln, 52)
      ev(e[i]);
    end
  endtask
  // ==========================================================
  // run control
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    wr(`CSMA_OFF_BIT_TIME, 32'h0000_0004, 2'h0);
    wr(`CSMA_OFF_SLOT_TIME, 32'h0000_0008, 2'h0);
    wr(`CSMA_OFF_GAP, 32'h0000_0008, 2'h0);
    wr(`CSMA_OFF_FRAME_CFG, 32'h0000_0408, 2'h0);
    t_slots();
    t_busy();
    t_collisions();
    stop_test();
  end
  initial
  begin
    #(8 * 20000);
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
